// file: verilog/crbc_ctrl.sv
// Purpose: Command/response buffer interface control with Wishbone register access.
// Assumes: Classic Wishbone master, single clock, synchronous reset.
// Notes:   Idle, Ready, Reception, Execution and Completion states.
//
// Notes on behaviour
// - Entering Idle sets the idle flag.
// - Idle flag never set outside Idle.
// - Ready request clears idle, enters Ready.
// - Reset leaves idle flag set.
// - Fatal flag set only by fatal error.
// - Cancel in Execution: respond, go Completion.
// - Finished gives result, terminated gives cancel code.
// - Cancelled command ends within long timeout.
// - Leaving execution on cancel clears start.
// - Nonzero cancel writes ignored outside Execution.
// - Cancel register reads back; 1 sets, 0 clears.
// - Start of 1 in Reception begins Execution.
// - Start of 1 elsewhere is ignored.
// - Software zero writes to start ignored.
// - Finishing clears start, enters Completion.
// - First buffer write moves Ready to Reception.
// - Initialisation and locality change enter Idle.
// - Go-idle in Completion enters Idle.
// - With bypass, ready request in Completion goes Ready.
// - Go-idle invalidates buffer and enters Idle.
// - Request writes ignored during Execution.
// - Status: idle bit 1, fatal bit 0.
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
module crbc_ctrl #(
    parameter logic        IDLE_BYPASS = 1'b1,          // Idle bypass capability
    parameter logic [15:0] IDENTITY    = 16'h5a5a,      // Arbitrary identity value
    parameter logic [31:0] CANCEL_CODE = 32'h0000_0c01, // Cancelled response code
    parameter int unsigned EXEC_CYCLES = crbc_pkg::EXEC_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        fatal_error_i,
    input  wire logic        locality_change_i,
    output logic             idle_o,
    output logic             fatal_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // Address falls in the buffer window
    function automatic logic in_buf(input logic [7:0] adr);
        return (adr & crbc_pkg::BUF_MASK) == crbc_pkg::BUF_BASE;
    endfunction : in_buf

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    crbc_pkg::crbc_state_t state;       // Current interface state
    crbc_pkg::crbc_state_t next_state;  // State for next cycle
    logic        idle_flag;             // Status idle bit
    logic        fatal_flag;            // Status fatal bit
    logic        fatal_s1;              // Fatal input sync, first stage
    logic        fatal_s2;              // Fatal input sync, second stage
    logic        loc_s1;                // Locality change sync, first stage
    logic        loc_s2;                // Locality change sync, second stage
    logic [1:0]  req;                   // Pending ready / go-idle requests
    logic [31:0] cancel_reg;            // Command cancel request
    logic [31:0] start_reg;             // Command start trigger
    logic [31:0] resp_code;             // Code of last response
    logic [31:0] buf_mem [crbc_pkg::BUF_WORDS]; // Command/response buffer
    logic [4:0]  wr_ptr;                // Next sequential write word
    logic [4:0]  rd_ptr;                // Next sequential read word
    logic        bus_req;               // Cycle addressed to us
    logic        wr_take;               // Write takes effect this edge
    logic [3:0]  bidx;                  // Buffer word index
    logic        buf_wr_ok;             // Accepted buffer write
    logic        start_go;              // Accepted start write
    logic        go_idle;               // Go-idle being processed
    logic        go_ready;              // Ready request being processed
    logic [31:0] wmerge;                // Merged write value
    logic [31:0] rd_val;                // Read data for this access

    crbc_exec_if ex ();

    assign bus_req = wb_cyc_i && wb_stb_i;
    assign wr_take = bus_req && wb_ack_o && wb_we_i;
    assign bidx    = wb_adr_i[5:2];
    assign go_idle  = req[crbc_pkg::REQ_GO_IDLE_BIT];
    assign go_ready = req[crbc_pkg::REQ_READY_BIT];

    // Merged value of the register being written
    always_comb begin
        wmerge = crbc_pkg::WORD_ZERO;
        if (wb_adr_i == crbc_pkg::OFS_CANCEL) begin
            wmerge = merge(cancel_reg, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == crbc_pkg::OFS_START) begin
            wmerge = merge(start_reg, wb_dat_i, wb_sel_i);
        end else if (in_buf(wb_adr_i)) begin
            wmerge = merge(buf_mem[bidx], wb_dat_i, wb_sel_i);
        end else begin
            wmerge = wb_dat_i;
        end
    end

    // Buffer writes only in Ready or Reception, from base then sequential
    assign buf_wr_ok = wr_take && in_buf(wb_adr_i) &&
                       (state == crbc_pkg::ST_READY || state == crbc_pkg::ST_RECEPTION) &&
                       (bidx == 4'h0 || {1'b0, bidx} == wr_ptr);
    // Start only a write of exactly one in Reception
    assign start_go = wr_take && (wb_adr_i == crbc_pkg::OFS_START) &&
                      (wmerge == crbc_pkg::TRIGGER_ONE) && (state == crbc_pkg::ST_RECEPTION);

    // ------------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------------
    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            if (bus_req && !wb_ack_o) begin
                wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_val;
            end
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (wb_adr_i == crbc_pkg::OFS_REQ) begin
            rd_val[1:0] = req;
        end else if (wb_adr_i == crbc_pkg::OFS_STS) begin
            rd_val[crbc_pkg::STS_IDLE_BIT]  = idle_flag;
            rd_val[crbc_pkg::STS_FATAL_BIT] = fatal_flag;
        end else if (wb_adr_i == crbc_pkg::OFS_CANCEL) begin
            rd_val = cancel_reg;
        end else if (wb_adr_i == crbc_pkg::OFS_START) begin
            rd_val = start_reg;
        end else if (wb_adr_i == crbc_pkg::OFS_INTF_ID) begin
            rd_val[crbc_pkg::INTF_BYPASS_BIT] = IDLE_BYPASS;
            rd_val[crbc_pkg::INTF_ID_LSB +: 16] = IDENTITY;
        end else if (wb_adr_i == crbc_pkg::OFS_RESP_CODE) begin
            rd_val = resp_code;
        end else if (in_buf(wb_adr_i) && state == crbc_pkg::ST_COMPLETION &&
                     (bidx == 4'h0 || {1'b0, bidx} == rd_ptr)) begin
            rd_val = buf_mem[bidx]; // Out-of-order reads return zero
        end else begin
            rd_val = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Two stages; only the second stage is used by logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fatal_s1 <= 1'b0;
            fatal_s2 <= 1'b0;
            loc_s1   <= 1'b0;
            loc_s2   <= 1'b0;
        end else begin
            fatal_s1 <= fatal_error_i;
            fatal_s2 <= fatal_s1;
            loc_s1   <= locality_change_i;
            loc_s2   <= loc_s1;
        end
    end

    // Fatal flag: sticky, only the fatal input sets it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fatal_flag <= 1'b0;
        end else if (fatal_s2) begin
            fatal_flag <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Request register
    // ------------------------------------------------------------------
    // Requests are held one cycle, acted on, then cleared by hardware.
    // A new write in the clearing cycle wins over the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req <= 2'b00;
        end else if (wr_take && wb_adr_i == crbc_pkg::OFS_REQ && wb_sel_i[0] &&
                     state != crbc_pkg::ST_EXECUTION) begin
            req <= wb_dat_i[1:0];
        end else begin
            req <= 2'b00; // Acknowledge by clearing
        end
    end

    // ------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------
    // Next state; go-idle wins over ready when both are written
    always_comb begin
        next_state = state;
        case (state)
            crbc_pkg::ST_IDLE: begin
                if (!go_idle && go_ready) begin
                    next_state = crbc_pkg::ST_READY;
                end
            end
            crbc_pkg::ST_READY: begin
                if (go_idle) begin
                    next_state = crbc_pkg::ST_IDLE;
                end else if (buf_wr_ok) begin
                    next_state = crbc_pkg::ST_RECEPTION;
                end
            end
            crbc_pkg::ST_RECEPTION: begin
                if (go_idle) begin
                    next_state = crbc_pkg::ST_IDLE;
                end else if (start_go) begin
                    next_state = crbc_pkg::ST_EXECUTION;
                end
            end
            crbc_pkg::ST_EXECUTION: begin
                if (ex.done) begin
                    next_state = crbc_pkg::ST_COMPLETION;
                end
            end
            crbc_pkg::ST_COMPLETION: begin
                if (go_idle) begin
                    next_state = crbc_pkg::ST_IDLE;
                end else if (go_ready && IDLE_BYPASS) begin
                    next_state = crbc_pkg::ST_READY;
                end
            end
            default: begin
                next_state = crbc_pkg::ST_IDLE;
            end
        endcase
        if (loc_s2) begin
            next_state = crbc_pkg::ST_IDLE;
        end
    end

    // State and idle flag; reset is the end of initialisation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state     <= crbc_pkg::ST_IDLE;
            idle_flag <= 1'b1;
        end else begin
            state     <= next_state;
            idle_flag <= (next_state == crbc_pkg::ST_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Cancel and start registers
    // ------------------------------------------------------------------
    // Any value taken during execution; elsewhere only a clear to zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cancel_reg <= crbc_pkg::CANCEL_RST;
        end else if (wr_take && wb_adr_i == crbc_pkg::OFS_CANCEL) begin
            if (state == crbc_pkg::ST_EXECUTION || wmerge == crbc_pkg::WORD_ZERO) begin
                cancel_reg <= wmerge;
            end
        end
    end

    // Only hardware clears start; software may only set it to one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_reg <= crbc_pkg::START_RST;
        end else if (state == crbc_pkg::ST_EXECUTION && (ex.done || loc_s2)) begin
            start_reg <= crbc_pkg::WORD_ZERO;
        end else if (start_go) begin
            start_reg <= crbc_pkg::TRIGGER_ONE;
        end
    end

    // ------------------------------------------------------------------
    // Buffer and response
    // ------------------------------------------------------------------
    // Buffer contents, write pointer, and response placement
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= 5'h00;
        end else if (state == crbc_pkg::ST_EXECUTION && ex.done) begin
            buf_mem[0] <= ex.cancelled ? CANCEL_CODE : ex.result;
            wr_ptr     <= 5'h00;
        end else if ((go_idle && state != crbc_pkg::ST_EXECUTION) || loc_s2) begin
            wr_ptr <= 5'h00; // Invalidate
        end else if (buf_wr_ok) begin
            buf_mem[bidx] <= wmerge;
            wr_ptr        <= {1'b0, bidx} + 5'h01;
        end
    end

    // Sequential read pointer; base read restarts it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_ptr <= 5'h00;
        end else if (state != crbc_pkg::ST_COMPLETION) begin
            rd_ptr <= 5'h00;
        end else if (bus_req && wb_ack_o && !wb_we_i && in_buf(wb_adr_i) &&
                     (bidx == 4'h0 || {1'b0, bidx} == rd_ptr)) begin
            rd_ptr <= {1'b0, bidx} + 5'h01;
        end
    end

    // Response code of the last command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resp_code <= crbc_pkg::RESP_NORMAL;
        end else if (state == crbc_pkg::ST_EXECUTION && ex.done) begin
            resp_code <= ex.cancelled ? CANCEL_CODE : crbc_pkg::RESP_NORMAL;
        end
    end

    // ------------------------------------------------------------------
    // Engine
    // ------------------------------------------------------------------
    // Cancel is checked every engine cycle, so it ends within one cycle;
    // a locality change also stops a running command.
    assign ex.start   = start_go;
    assign ex.cancel  = (state == crbc_pkg::ST_EXECUTION) &&
                        (cancel_reg == crbc_pkg::TRIGGER_ONE || loc_s2);
    assign ex.cmd_len = wr_ptr;
    assign ex.rd_data = buf_mem[ex.rd_idx];

    crbc_engine #(
        .EXEC_CYCLES (EXEC_CYCLES)
    ) u_engine (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ex    (ex.engine)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign idle_o  = idle_flag;
    assign fatal_o = fatal_flag;

endmodule : crbc_ctrl

// file: verilog/crbc_pkg.sv
// Purpose: Shared constants and types of the command/response buffer control block.
// Assumes: 8-bit Wishbone byte address, 32-bit data, one word per register.
// Notes:   Every offset, the field positions and the cancel, start and response code reset values live here.
package crbc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_REQ       = 8'h00; // Control request register
    localparam logic [7:0] OFS_STS       = 8'h04; // Control status register
    localparam logic [7:0] OFS_CANCEL    = 8'h08; // Command cancel request
    localparam logic [7:0] OFS_START     = 8'h0c; // Command start trigger
    localparam logic [7:0] OFS_INTF_ID   = 8'h10; // Interface identity register
    localparam logic [7:0] OFS_RESP_CODE = 8'h14; // Response code of last command
    localparam logic [7:0] BUF_BASE      = 8'h80; // Command/response buffer window
    localparam logic [7:0] BUF_MASK      = 8'hc0; // Window is 64 bytes

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned REQ_READY_BIT   = 0; // Ready request
    localparam int unsigned REQ_GO_IDLE_BIT = 1; // Go-idle request
    localparam int unsigned STS_FATAL_BIT   = 0; // Fatal error flag
    localparam int unsigned STS_IDLE_BIT    = 1; // Idle flag
    localparam int unsigned INTF_BYPASS_BIT = 0; // Idle bypass capability
    localparam int unsigned INTF_ID_LSB     = 16; // Identity field base

    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic [31:0] CANCEL_RST   = 32'h0000_0000; // Cancel after reset
    localparam logic [31:0] START_RST    = 32'h0000_0000; // Start after reset
    localparam logic [31:0] TRIGGER_ONE  = 32'h0000_0001; // Request value
    localparam logic [31:0] WORD_ZERO    = 32'h0000_0000; // Cleared value
    localparam logic [31:0] RESP_NORMAL  = 32'h0000_0000; // Normal completion code

    // ------------------------------------------------------------------
    // Buffer geometry and timing
    // ------------------------------------------------------------------
    localparam int unsigned BUF_WORDS   = 16; // Buffer depth in words
    localparam int unsigned IDX_W       = 4;  // Word index width
    localparam int unsigned LEN_W       = 5;  // Command length width
    localparam int unsigned EXEC_CYCLES = 8;  // Least execution time in cycles

    // ------------------------------------------------------------------
    // Interface states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READY,
        ST_RECEPTION,
        ST_EXECUTION,
        ST_COMPLETION
    } crbc_state_t;

endpackage : crbc_pkg

// file: verilog/crbc_exec_if.sv
// Purpose: Link between the interface control and the command engine.
// Assumes: Both ends on the same clock.
// Notes:   start and done are one-cycle pulses; cancel is a level.
interface crbc_exec_if;
    logic        start;     // Begin processing, one cycle
    logic        cancel;    // Terminate request, level
    logic [4:0]  cmd_len;   // Command length in words
    logic [3:0]  rd_idx;    // Buffer word the engine reads
    logic [31:0] rd_data;   // Buffer word contents
    logic        done;      // Processing ended, one cycle
    logic        cancelled; // Ended by termination
    logic [31:0] result;    // Response word

    modport ctrl   (output start, cancel, cmd_len, rd_data, input rd_idx, done, cancelled, result);
    modport engine (input start, cancel, cmd_len, rd_data, output rd_idx, done, cancelled, result);
endinterface : crbc_exec_if

// file: verilog/crbc_engine.sv
// Purpose: Command engine: folds the buffered command into a response word.
// Assumes: Started only while idle; buffer stable during processing.
// Notes:   Checks cancel on every cycle, so a cancel ends it in one cycle.
module crbc_engine #(
    parameter int unsigned EXEC_CYCLES = crbc_pkg::EXEC_CYCLES
) (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    crbc_exec_if.engine ex
);

    // ------------------------------------------------------------------
    // Processing state
    // ------------------------------------------------------------------
    logic        busy;  // Command in progress
    logic [4:0]  idx;   // Next word to fold
    logic [4:0]  len;   // Captured length
    logic [31:0] acc;   // Running fold
    logic [7:0]  cnt;   // Cycles spent

    // Finished once all words folded and least time spent
    logic finish;
    assign finish = (idx >= len) && (cnt >= 8'(EXEC_CYCLES - 1));
    assign ex.rd_idx = idx[3:0];

    // Busy flag, counters and fold
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            idx  <= 5'h00;
            len  <= 5'h00;
            acc  <= 32'h0000_0000;
            cnt  <= 8'h00;
        end else if (ex.start && !busy) begin
            busy <= 1'b1;
            idx  <= 5'h00;
            len  <= ex.cmd_len;
            acc  <= 32'h0000_0000;
            cnt  <= 8'h00;
        end else if (busy) begin
            // Cancel seen at a checkpoint ends the work
            if (ex.cancel || finish) begin
                busy <= 1'b0;
            end else begin
                if (idx < len) begin
                    acc <= {acc[30:0], acc[31]} ^ ex.rd_data;
                    idx <= idx + 5'h01;
                end
                cnt <= cnt + 8'h01;
            end
        end
    end

    // Outcome, registered one cycle wide
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ex.done      <= 1'b0;
            ex.cancelled <= 1'b0;
            ex.result    <= 32'h0000_0000;
        end else begin
            ex.done <= busy && (ex.cancel || finish);
            if (busy && (ex.cancel || finish)) begin
                ex.cancelled <= ex.cancel; // Terminated rather than finished
                ex.result    <= ex.cancel ? 32'h0000_0000 : acc;
            end
        end
    end

endmodule : crbc_engine

// file: verification/crbc_asserts.sv
// Purpose: Port checks of crbc_ctrl
// Assumes: One clock, reset high
// Notes:   Bound to every crbc_ctrl
module crbc_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        fatal_error_i,
    input wire logic        locality_change_i,
    input wire logic        idle_o,
    input wire logic        fatal_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request register write landing
    wire req_wr = wb_ack_o && wb_we_i && wb_adr_i == crbc_pkg::OFS_REQ;
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_delay: assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o) else $error("ack late");
    a_ack_cause: assert property (!wb_stb_i |=> !wb_ack_o) else $error("stray ack");
    a_idle_ready: assert property (req_wr && wb_dat_i[1:0] == 2'h1 && idle_o |-> ##[1:2] !idle_o)
        else $error("idle kept");
    a_idle_local: assert property (locality_change_i [*3] |-> ##[0:3] idle_o)
        else $error("idle missing");
    a_reset_flags: assert property ($fell(rst_i) |-> idle_o && !fatal_o) else $error("bad reset");
    a_fatal_cause: assert property ($rose(fatal_o) |-> $past(fatal_error_i, 2) || $past(fatal_error_i, 3))
        else $error("fatal uncaused");
    a_status_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == crbc_pkg::OFS_STS |->
        wb_dat_o == {30'h0, idle_o, fatal_o}) else $error("bad status");
endmodule : crbc_asserts
bind crbc_ctrl crbc_asserts chk (.*);

// file: verification/crbc_host.sv
// Purpose: Host driver model on classic Wishbone
// Assumes: Waits for ack as long as it takes
// Notes:   Released data shows the inverse word
module crbc_host (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o = 1'b0,
    output logic             we_o = 1'b0,
    output logic [7:0]       adr_o = 8'h00,
    output logic [31:0]      dat_o = 32'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // One single cycle, held until ack
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        dat_o <= ~d;
    endtask : xfer
endmodule : crbc_host

// file: verification/testbench.sv
// Purpose: Bench of crbc_ctrl
// Assumes: Host model owns the bus
// Notes:   Long execution so refusals land mid-run
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 0, rst_i = 1, cyc, we, ack, fe = 0, lc = 0, idle, fat;
    logic [7:0]  adr;
    logic [31:0] wd, rd, v;
    int          fails = 0, checked = 0;
    always #50 clk_i = ~clk_i;
    crbc_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc), .we_o(we), .adr_o(adr), .dat_o(wd));
    crbc_ctrl #(.EXEC_CYCLES(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
        .fatal_error_i(fe), .locality_change_i(lc), .idle_o(idle), .fatal_o(fat));
    task automatic chk(input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, v);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, v);
        chk(v, e);
    endtask : rc
    // One command, cancelled when c is set
    task automatic t_cmd(input logic c, input logic [31:0] code, input logic [31:0] rsp);
        wr(crbc_pkg::OFS_REQ, 32'h1);
        rc(crbc_pkg::OFS_STS, 32'h0);
        wr(crbc_pkg::BUF_BASE, 32'h7);
        wr(crbc_pkg::OFS_START, 32'h1);
        wr(crbc_pkg::OFS_START, 32'h0);
        rc(crbc_pkg::OFS_START, 32'h1);
        wr(crbc_pkg::OFS_REQ, 32'h2);
        wr(crbc_pkg::OFS_CANCEL, {31'h0, c});
        rc(crbc_pkg::OFS_CANCEL, {31'h0, c});
        v = 32'h1;
        for (int i = 0; i < 60 && v !== 32'h0; i++) host.xfer(1'b0, crbc_pkg::OFS_START, 32'h0, v);
        chk(v, 32'h0);
        rc(crbc_pkg::OFS_STS, 32'h0);
        rc(crbc_pkg::OFS_RESP_CODE, code);
        rc(crbc_pkg::BUF_BASE, rsp);
        wr(crbc_pkg::OFS_CANCEL, 32'h0);
        wr(crbc_pkg::OFS_CANCEL, 32'h1);
        rc(crbc_pkg::OFS_CANCEL, 32'h0);
    endtask : t_cmd
    // Reset state, start refused in Idle, capability word
    task automatic t_reset;
        rc(crbc_pkg::OFS_STS, 32'h2);
        wr(crbc_pkg::OFS_START, 32'h1);
        rc(crbc_pkg::OFS_START, 32'h0);
        rc(crbc_pkg::OFS_INTF_ID, 32'h5a5a_0001);
    endtask : t_reset
    // Locality change forces Idle, then the fatal input sets its flag
    task automatic t_loc;
        wr(crbc_pkg::OFS_REQ, 32'h1);
        lc <= 1'b1;
        repeat (6) @(posedge clk_i);
        lc <= 1'b0;
        fe <= 1'b1;
        rc(crbc_pkg::OFS_STS, 32'h2);
        repeat (5) @(posedge clk_i);
        rc(crbc_pkg::OFS_STS, 32'h3);
    endtask : t_loc
    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_cmd(1'b0, crbc_pkg::RESP_NORMAL, 32'h0000_0007);
        t_cmd(1'b1, 32'h0000_0c01, 32'h0000_0c01);
        wr(crbc_pkg::OFS_REQ, 32'h2);
        rc(crbc_pkg::OFS_STS, 32'h2);
        rc(8'h40, 32'h0);
        t_loc;
        test_done;
    end
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        test_done;
    end
endmodule : testbench
